// ===== rtl/mlsd_scan_driver.sv
// LED scan driver: register file, segment scanner and tri-state pin drive
`timescale 1ns/1ps
`include "mlsd_regs.svh"
module mlsd_scan_driver #(
	parameter int TIME_W = 16
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [`MLSD_ADDR_W-1:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic [7:0] led_pin_in,
	output logic [7:0] led_pin_out,
	output logic [7:0] led_pin_oe_out,
	output logic [7:0] led_pin_owned_out
);
	mlsd_pkg::mlsd_top_state_s st;
	mlsd_pkg::mlsd_top_state_s next_st;
	logic slot_end;
	logic on_window;
	logic timer_run;
	logic pat_bit;
	logic [63:0] seg_bits;

	function automatic logic [7:0] pin_mask(input logic [1:0] sel);
		logic [7:0] m;
		m = 8'hff;
		unique case (sel)
			2'h1: begin
				m = 8'h3f;
			end
			2'h2: begin
				m = 8'h7f;
			end
			default: begin
				m = 8'hff;
			end
		endcase
		return m;
	endfunction : pin_mask

	function automatic logic [3:0] last_pin(input logic [1:0] sel);
		logic [3:0] l;
		l = 4'h7;
		unique case (sel)
			2'h1: begin
				l = 4'h5;
			end
			2'h2: begin
				l = 4'h6;
			end
			default: begin
				l = 4'h7;
			end
		endcase
		return l;
	endfunction : last_pin

	assign timer_run = (st.mode == mlsd_pkg::MLSD_SCAN) && st.cfg.run;

	mlsd_slot_timer #(
		.CNT_W(TIME_W)
	) u_slot_timer (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.run_in(timer_run),
		.period_in(st.cfg.period),
		.on_time_in(st.cfg.on_time),
		.slot_end_out(slot_end),
		.on_window_out(on_window)
	);

	// Segments 0-3 in the lower word, 4-7 in the upper word
	assign seg_bits = {st.cfg.seg_upper, st.cfg.seg_lower};
	// A stale position after the selection shrinks must not light a lone anode
	assign pat_bit = seg_bits[{st.seg, st.anode}]
		&& ({1'b0, st.seg} <= last_pin(st.cfg.count_sel))
		&& ({1'b0, st.anode} <= last_pin(st.cfg.count_sel));

	assign rdata_out = st.rdata;
	assign led_pin_out = st.pins.drive;
	assign led_pin_oe_out = st.pins.oe;
	assign led_pin_owned_out = st.pins.owned;

	always_comb begin
		logic [3:0] a_nxt;
		logic [3:0] s_nxt;
		logic [3:0] last;
		a_nxt = 4'h0;
		s_nxt = 4'h0;
		last = last_pin(st.cfg.count_sel);
		next_st = st;
		next_st.rdata = 32'h0000_0000;

		// Pin readback; a level counts once two stages agree
		next_st.sync1 = led_pin_in;
		next_st.sync2 = st.sync1;
		next_st.sync3 = st.sync2;
		if (st.sync2 == st.sync3) begin
			next_st.pin_level = st.sync3;
		end

		if (wr_in) begin
			case (addr_in)
				`MLSD_OFF_CONTROL: begin
					next_st.cfg.run = wdata_in[`MLSD_RUN_BIT];
					next_st.cfg.count_sel = wdata_in[`MLSD_CNT_MSB:`MLSD_CNT_LSB];
				end
				`MLSD_OFF_PERIOD: begin
					next_st.cfg.period = wdata_in[`MLSD_TIME_MSB:0];
				end
				`MLSD_OFF_ON_TIME: begin
					next_st.cfg.on_time = wdata_in[`MLSD_TIME_MSB:0];
				end
				`MLSD_OFF_SEG_UPPER: begin
					next_st.cfg.seg_upper = wdata_in;
				end
				`MLSD_OFF_SEG_LOWER: begin
					next_st.cfg.seg_lower = wdata_in;
				end
				default: begin
				end
			endcase
		end

		if (rd_in) begin
			case (addr_in)
				`MLSD_OFF_CONTROL: begin
					next_st.rdata[`MLSD_RUN_BIT] = st.cfg.run;
					next_st.rdata[`MLSD_CNT_MSB:`MLSD_CNT_LSB] = st.cfg.count_sel;
				end
				`MLSD_OFF_PERIOD: begin
					next_st.rdata[`MLSD_TIME_MSB:0] = st.cfg.period;
				end
				`MLSD_OFF_ON_TIME: begin
					next_st.rdata[`MLSD_TIME_MSB:0] = st.cfg.on_time;
				end
				`MLSD_OFF_SEG_UPPER: begin
					next_st.rdata = st.cfg.seg_upper;
				end
				`MLSD_OFF_SEG_LOWER: begin
					next_st.rdata = st.cfg.seg_lower;
				end
				`MLSD_OFF_STATUS: begin
					next_st.rdata[`MLSD_ST_SCAN_BIT] = (st.mode == mlsd_pkg::MLSD_SCAN);
					next_st.rdata[`MLSD_ST_WIN_BIT] = on_window;
					next_st.rdata[`MLSD_ST_SEG_LSB+:3] = st.seg;
					next_st.rdata[`MLSD_ST_ANODE_LSB+:3] = st.anode;
					next_st.rdata[`MLSD_ST_LEVEL_LSB+:8] = st.pin_level;
				end
				default: begin
					next_st.rdata = 32'h0000_0000;
				end
			endcase
		end

		unique case (st.mode)
			mlsd_pkg::MLSD_IDLE: begin
				next_st.seg = 3'h0;
				next_st.anode = 3'h1;
				if (st.cfg.run) begin
					next_st.mode = mlsd_pkg::MLSD_SCAN;
				end
			end
			mlsd_pkg::MLSD_SCAN: begin
				if (!st.cfg.run) begin
					next_st.mode = mlsd_pkg::MLSD_IDLE;
					next_st.seg = 3'h0;
					next_st.anode = 3'h1;
				end else if (({1'b0, st.seg} > last) || ({1'b0, st.anode} > last)) begin
					// Selection shrank under a running scan: restart cleanly
					next_st.seg = 3'h0;
					next_st.anode = 3'h1;
				end else if (slot_end) begin
					a_nxt = {1'b0, st.anode} + 4'h1;
					s_nxt = {1'b0, st.seg};
					if (a_nxt == s_nxt) begin
						a_nxt = a_nxt + 4'h1;
					end
					if (a_nxt > last) begin
						s_nxt = s_nxt + 4'h1;
						if (s_nxt > last) begin
							s_nxt = 4'h0;
						end
						a_nxt = (s_nxt == 4'h0) ? 4'h1 : 4'h0;
					end
					next_st.seg = s_nxt[2:0];
					next_st.anode = a_nxt[2:0];
				end
			end
		endcase

		// Only common and one anode ever leave high impedance
		next_st.pins.owned = pin_mask(st.cfg.count_sel);
		next_st.pins.drive = 8'h00;
		next_st.pins.oe = 8'h00;
		if (timer_run && on_window && pat_bit) begin
			next_st.pins.oe[st.seg] = 1'b1;
			next_st.pins.oe[st.anode] = 1'b1;
			next_st.pins.drive[st.anode] = 1'b1;
		end
		next_st.pins.oe = next_st.pins.oe & next_st.pins.owned;
		next_st.pins.drive = next_st.pins.drive & next_st.pins.owned;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '0;
			st.cfg.run <= 1'(`MLSD_RST_CONTROL >> `MLSD_RUN_BIT);
			st.cfg.period <= 16'(`MLSD_RST_PERIOD);
			st.cfg.on_time <= 16'(`MLSD_RST_ON_TIME);
			st.cfg.seg_upper <= `MLSD_RST_SEG;
			st.cfg.seg_lower <= `MLSD_RST_SEG;
			st.anode <= 3'h1;
			st.pins.owned <= 8'hff;
		end else begin
			st <= next_st;
		end
	end

	one_led_lit_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		$onehot0(st.pins.drive & st.pins.oe))
		else $error("more than one anode driven high");

	serial_drive_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(st.pins.oe != 8'h00) |-> ($countones(st.pins.oe) == 2))
		else $error("pin drive is not one common plus one anode");

	tri_state_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		((st.pins.drive & ~st.pins.oe) == 8'h00)
		&& ((st.pins.oe == 8'h00) || ($countones(st.pins.oe & ~st.pins.drive) == 1)))
		else $error("pin drives high while floating or lacks a low common");

	drive_window_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(st.pins.oe != 8'h00) |-> $past(on_window && timer_run))
		else $error("LED driven outside the on-time window");

	pattern_gate_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		$past(timer_run && on_window) |-> ((st.pins.oe != 8'h00) == $past(pat_bit)))
		else $error("pin drive disagrees with the segment pattern");

	lit_pins_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(st.pins.oe != 8'h00) |-> (st.pins.drive[$past(st.anode)] && !st.pins.drive[$past(st.seg)]))
		else $error("anode or common on the wrong pin");

	owned_mask_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		##1 ((st.pins.owned == pin_mask($past(st.cfg.count_sel)))
		&& ((st.pins.oe & ~st.pins.owned) == 8'h00)))
		else $error("pin ownership disagrees with the count select");

	run_start_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(st.cfg.run && st.mode == mlsd_pkg::MLSD_IDLE) |=> (st.mode == mlsd_pkg::MLSD_SCAN))
		else $error("scan did not start after run set");

	stop_float_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(!st.cfg.run ##1 !st.cfg.run) |-> ##1 (st.pins.oe == 8'h00 && st.seg == 3'h0 && st.anode == 3'h1))
		else $error("pins or counters not parked while stopped");

	scan_step_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(slot_end && st.cfg.run && {1'b0, st.seg} <= last_pin(st.cfg.count_sel)
		&& {1'b0, st.anode} <= last_pin(st.cfg.count_sel))
		|=> (st.seg != st.anode) && ({st.seg, st.anode} != $past({st.seg, st.anode})))
		else $error("scan did not move to a new LED at slot end");

	run_stop_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(!st.cfg.run && st.mode == mlsd_pkg::MLSD_SCAN) |=> (st.mode == mlsd_pkg::MLSD_IDLE))
		else $error("scan did not stop after run cleared");

	run_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(wr_in && addr_in == `MLSD_OFF_CONTROL) |=> (st.cfg.run == $past(wdata_in[`MLSD_RUN_BIT])))
		else $error("run bit not taken from the control write");

	count_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(wr_in && addr_in == `MLSD_OFF_CONTROL) |=> (st.cfg.count_sel == $past(wdata_in[`MLSD_CNT_MSB:`MLSD_CNT_LSB])))
		else $error("count select not taken from the control write");

	period_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(wr_in && addr_in == `MLSD_OFF_PERIOD) |=> (st.cfg.period == $past(wdata_in[`MLSD_TIME_MSB:0])))
		else $error("slot period not taken from the write");

	on_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(wr_in && addr_in == `MLSD_OFF_ON_TIME) |=> (st.cfg.on_time == $past(wdata_in[`MLSD_TIME_MSB:0])))
		else $error("on time not taken from the write");

	upper_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(wr_in && addr_in == `MLSD_OFF_SEG_UPPER) |=> (st.cfg.seg_upper == $past(wdata_in)))
		else $error("upper patterns not taken from the write");

	lower_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(wr_in && addr_in == `MLSD_OFF_SEG_LOWER) |=> (st.cfg.seg_lower == $past(wdata_in)))
		else $error("lower patterns not taken from the write");

	released_pins_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(((st.pins.oe | st.pins.drive) & ~st.pins.owned) == 8'h00))
		else $error("released pin still driven");

	idle_float_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(st.mode == mlsd_pkg::MLSD_IDLE) |=> (st.pins.oe == 8'h00))
		else $error("pin driven while stopped");

	idle_park_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(st.mode == mlsd_pkg::MLSD_IDLE) |=> (st.seg == 3'h0 && st.anode == 3'h1))
		else $error("scan position not parked while stopped");

	scan_wrap_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(slot_end && st.cfg.run && {1'b0, st.seg} == last_pin(st.cfg.count_sel)
		&& {1'b0, st.anode} + 4'h1 == last_pin(st.cfg.count_sel)) |=> (st.seg == 3'h0 && st.anode == 3'h1))
		else $error("scan did not wrap after the last LED");

	seg_advance_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(slot_end && st.cfg.run && {1'b0, st.seg} < last_pin(st.cfg.count_sel)
		&& {1'b0, st.anode} == last_pin(st.cfg.count_sel)) |=> (st.seg == $past(st.seg) + 3'h1 && st.anode == 3'h0))
		else $error("scan did not move to the next segment");

	window_off_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(timer_run && !on_window) |=> (st.pins.oe == 8'h00))
		else $error("pin driven after the on time ran out");

	one_high_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		($countones(st.pins.drive) <= 1))
		else $error("more than one pin driven high");

	rdata_idle_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!rd_in |=> (st.rdata == 32'h0000_0000))
		else $error("read data not cleared outside a read");
endmodule : mlsd_scan_driver

// ===== rtl/mlsd_regs.svh
// Register offsets, field positions, reset values and counts of the LED scan driver
`ifndef MLSD_REGS_SVH
`define MLSD_REGS_SVH
`define MLSD_ADDR_W 8
`define MLSD_OFF_CONTROL 8'h00
`define MLSD_OFF_PERIOD 8'h04
`define MLSD_OFF_ON_TIME 8'h08
`define MLSD_OFF_SEG_UPPER 8'h0c
`define MLSD_OFF_SEG_LOWER 8'h10
`define MLSD_OFF_STATUS 8'h14
`define MLSD_RUN_BIT 0
`define MLSD_CNT_LSB 4
`define MLSD_CNT_MSB 5
`define MLSD_TIME_MSB 15
`define MLSD_ST_SCAN_BIT 0
`define MLSD_ST_WIN_BIT 1
`define MLSD_ST_SEG_LSB 4
`define MLSD_ST_ANODE_LSB 8
`define MLSD_ST_LEVEL_LSB 16
`define MLSD_RST_CONTROL 32'h0000_0000
`define MLSD_RST_PERIOD 32'h0000_0000
`define MLSD_RST_ON_TIME 32'h0000_0000
`define MLSD_RST_SEG 32'h0000_0000
`define MLSD_PINS 8
`define MLSD_SLOTS 56
`endif

// ===== rtl/mlsd_pkg.sv
// Types shared by the LED scan driver modules
package mlsd_pkg;
	typedef enum logic [0:0] {
		MLSD_IDLE = 1'b0,
		MLSD_SCAN = 1'b1
	} mlsd_mode_e;

	typedef struct packed {
		logic run;
		logic [1:0] count_sel;
		logic [15:0] period;
		logic [15:0] on_time;
		logic [31:0] seg_upper;
		logic [31:0] seg_lower;
	} mlsd_cfg_s;

	typedef struct packed {
		logic [7:0] drive;
		logic [7:0] oe;
		logic [7:0] owned;
	} mlsd_pins_s;

	typedef struct packed {
		mlsd_cfg_s cfg;
		mlsd_mode_e mode;
		logic [2:0] seg;
		logic [2:0] anode;
		logic [31:0] rdata;
		mlsd_pins_s pins;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] sync3;
		logic [7:0] pin_level;
	} mlsd_top_state_s;
endpackage : mlsd_pkg

// ===== rtl/mlsd_slot_timer.sv
// Slot timer: counts one scan slot and marks the drive window inside it
`timescale 1ns/1ps
module mlsd_slot_timer #(
	parameter int CNT_W = 16
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic run_in,
	input wire logic [CNT_W-1:0] period_in,
	input wire logic [CNT_W-1:0] on_time_in,
	output logic slot_end_out,
	output logic on_window_out
);
	typedef struct packed {
		logic [CNT_W-1:0] count;
	} mlsd_timer_state_s;

	mlsd_timer_state_s st;
	mlsd_timer_state_s next_st;

	// Slot lasts period + 1 clocks
	assign slot_end_out = run_in && (st.count >= period_in);
	// Drive only for the first on_time clocks of the slot
	assign on_window_out = run_in && (st.count < on_time_in);

	always_comb begin
		next_st = st;
		if (!run_in) begin
			next_st.count = '0;
		end else if (slot_end_out) begin
			// Compare with >= so a shrunken period cannot run past it
			next_st.count = '0;
		end else begin
			next_st.count = st.count + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	slot_count_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(run_in && st.count < period_in) |=> (!run_in || st.count == $past(st.count) + 1'b1))
		else $error("slot counter did not advance");

	slot_wrap_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(run_in && st.count == period_in) |=> (st.count == '0))
		else $error("slot counter did not wrap at period");
endmodule : mlsd_slot_timer

// ===== bench/mlsd_led_model.sv
// LED matrix model hung across the eight scan pins
`timescale 1ns/1ps
module mlsd_led_model (
	input wire logic ref_clk_in,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] oe_in,
	output logic [7:0] wire_out,
	output logic [5:0] lit_out
);
	logic [7:0] last_lvl = 8'h00;
	// No pull resistors: a released pin shows the inverse of its last driven level
	always @(posedge ref_clk_in) begin
		for (int p = 0; p < 8; p++) begin
			if (oe_in[p] === 1'b1) last_lvl[p] <= pin_in[p];
		end
	end
	assign wire_out = (pin_in & oe_in) | (~last_lvl & ~oe_in);
	// Lit only with anode driven high against a driven low common
	always_comb begin
		lit_out = 6'h00;
		for (int s = 0; s < 8; s++) begin
			for (int a = 0; a < 8; a++) begin
				if (s != a && oe_in[s] && !pin_in[s] && oe_in[a] && pin_in[a]) begin
					lit_out = lit_out + 6'h01;
				end
			end
		end
	end
endmodule : mlsd_led_model

// ===== bench/multiplexed_led_scan_driver_bench.sv
// Self-checking bench of the LED scan driver
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
	num_checks++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("unexpected %s: expected %h, seen %h", what, exp, got); \
	end \
end
module multiplexed_led_scan_driver_bench;
	logic ref_clk_in;
	logic rst_n_in;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic [7:0] pin_out, pin_oe, pin_owned, pin_wire;
	logic [5:0] lit;
	int mismatches, num_checks, cyc;
	mlsd_scan_driver u_mlsd_scan_driver (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .led_pin_in(pin_wire),
		.led_pin_out(pin_out), .led_pin_oe_out(pin_oe), .led_pin_owned_out(pin_owned));
	mlsd_led_model u_mlsd_led_model (.ref_clk_in(ref_clk_in), .pin_in(pin_out), .oe_in(pin_oe),
		.wire_out(pin_wire), .lit_out(lit));
	initial begin
		ref_clk_in = 1'b0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
	end
	// Judged mid-cycle, where the registered pins have settled
	always @(negedge ref_clk_in) begin
		if (rst_n_in) `CHK("lit count", 1'b1, lit <= 6'h01)
	end
	task wrap_up();
		$display("checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up
	task bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk_in);
		wr <= 1'b0;
	endtask : bus_wr
	task bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk_in);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : bus_rd
	// Bounded hunt for the next drive start; ends one step after the edge
	task next_start(output int t);
		int i;
		@(posedge ref_clk_in) #1;
		for (i = 0; i < 1000 && pin_oe !== 8'h00; i++) @(posedge ref_clk_in) #1;
		for (; i < 1000 && pin_oe === 8'h00; i++) @(posedge ref_clk_in) #1;
		if (i >= 1000) begin
			mismatches++;
			wrap_up();
		end
		t = cyc;
	endtask : next_start
	task reset_values();
		logic [31:0] d;
		`CHK("owned", 8'hff, pin_owned)
		`CHK("enable", 8'h00, pin_oe)
		for (int i = 0; i < 5; i++) begin
			bus_rd(8'(i * 4), d);
			`CHK("reset value", 32'h0, d)
		end
		bus_rd(8'h20, d);
		`CHK("unmapped", 32'h0, d)
		bus_rd(8'h14, d);
		`CHK("status", 32'h00ff_0100, d)
		bus_wr(8'h04, 32'hffff_1234);
		bus_rd(8'h04, d);
		`CHK("period", 32'h0000_1234, d)
		bus_wr(8'h08, 32'hffff_0002);
		bus_rd(8'h08, d);
		`CHK("on time", 32'h0000_0002, d)
		bus_wr(8'h0c, 32'h1234_5678);
		bus_rd(8'h0c, d);
		`CHK("upper", 32'h1234_5678, d)
		bus_wr(8'h00, 32'hffff_ffff);
		bus_rd(8'h00, d);
		`CHK("control", 32'h0000_0031, d)
		bus_wr(8'h00, 32'h0);
	endtask : reset_values
	// All legal patterns set, so every slot drives; one wrap is seen
	task scan_order(input logic [1:0] sel, input int n, input int per, input int on);
		int s, a, k, t, prev, w;
		bus_wr(8'h04, per);
		bus_wr(8'h08, on);
		bus_wr(8'h0c, 32'h7fbf_dfef);
		bus_wr(8'h10, 32'hf7fb_fdfe);
		bus_wr(8'h00, {26'h0, sel, 4'h1});
		s = 0;
		a = 1;
		prev = -1;
		for (k = 0; k <= n * (n - 1); k++) begin
			next_start(t);
			`CHK("enable", (8'h01 << s) | (8'h01 << a), pin_oe)
			`CHK("level", 8'h01 << a, pin_out)
			`CHK("lit", 6'h01, lit)
			`CHK("owned", 8'hff >> (8 - n), pin_owned)
			if (prev >= 0) `CHK("slot", per + 1, t - prev)
			prev = t;
			w = 0;
			while (pin_oe !== 8'h00 && w < 100) begin
				w++;
				@(posedge ref_clk_in) #1;
			end
			`CHK("on time", on, w)
			a++;
			if (a == s) a++;
			if (a >= n) begin
				s = (s + 1) % n;
				a = (s == 0) ? 1 : 0;
			end
		end
		bus_wr(8'h00, 32'h0);
		repeat (2) @(posedge ref_clk_in);
		#1 `CHK("stopped", 8'h00, pin_oe)
	endtask : scan_order
	// One lit LED only: the gap between its drives is the whole scan
	task full_scan();
		int t0, t1;
		bus_wr(8'h04, 32'h3);
		bus_wr(8'h08, 32'h1);
		bus_wr(8'h0c, 32'h4000_0000);
		bus_wr(8'h10, 32'h0);
		bus_wr(8'h00, 32'h1);
		next_start(t0);
		`CHK("enable", 8'hc0, pin_oe)
		`CHK("level", 8'h40, pin_out)
		next_start(t1);
		`CHK("scan time", 56 * 4, t1 - t0)
		bus_wr(8'h00, 32'h0);
	endtask : full_scan
	initial begin
		rst_n_in = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		repeat (3) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		@(posedge ref_clk_in) #1;
		reset_values();
		scan_order(2'b00, 8, 3, 1);
		scan_order(2'b01, 6, 3, 1);
		scan_order(2'b10, 7, 5, 3);
		scan_order(2'b11, 8, 4, 2);
		full_scan();
		wrap_up();
	end
endmodule : multiplexed_led_scan_driver_bench
